// *** dv/usart_frame_transmitter_test.sv ***
// Self-checking bench for the frame transmitter
`timescale 1ns/100ps
module usart_frame_transmitter_test;
	logic clk, rst_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic serial_out_pin, serial_out_oe_n, serial_in_pin, transfer_clock_pin_in;
	logic transfer_clock_pin_out, transfer_clock_pin_oe_n, xck, line;
	logic [4:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, rv;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, resp;
	logic [12:0] got;
	int n_mismatch, n_checks, cyc, k;
	// Wire levels from all drivers, pull-up on the serial line
	assign transfer_clock_pin_in = transfer_clock_pin_oe_n ? xck : transfer_clock_pin_out;
	assign line = serial_out_oe_n ? 1'b1 : serial_out_pin;
	usftx_top u_dut (.*);
	usftx_remote u_remote (.clk(clk), .tx_line(line), .rx_line(serial_in_pin), .xck(xck));
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc == 40000) begin
			n_mismatch++;
			end_of_test();
		end
	end
	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("unexpected %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic wr(input logic [4:0] a, input logic [31:0] d, output logic [1:0] r);
		logic ha, hw;
		ha = 1'b0;
		hw = 1'b0;
		@(posedge clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!(ha && hw)) begin
			@(negedge clk);
			ha = ha | (s_axi_awvalid & s_axi_awready);
			hw = hw | (s_axi_wvalid & s_axi_wready);
			@(posedge clk);
			if (ha) s_axi_awvalid <= 1'b0;
			if (hw) s_axi_wvalid <= 1'b0;
		end
		do @(negedge clk); while (s_axi_bvalid !== 1'b1);
		r = s_axi_bresp;
		@(posedge clk);
		s_axi_bready <= 1'b0;
	endtask
	task automatic rd(input logic [4:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(negedge clk); while (s_axi_arready !== 1'b1);
		@(posedge clk);
		s_axi_arvalid <= 1'b0;
		do @(negedge clk); while (s_axi_rvalid !== 1'b1);
		d = s_axi_rdata;
		r = s_axi_rresp;
		@(posedge clk);
		s_axi_rready <= 1'b0;
	endtask
	task automatic cfg(input logic [7:0] cc, input logic [3:0] cb);
		wr(usftx_pkg::OFF_CTRL_C, {24'h0, cc}, resp);
		wr(usftx_pkg::OFF_CTRL_B, {28'h0, cb}, resp);
	endtask
	// Start low, data from bit 0 up, optional parity, ones beyond
	function automatic logic [12:0] frame(input logic [8:0] d, input int nb, input logic pe,
		input logic odd);
		logic [12:0] f;
		logic p;
		f = '1;
		f[0] = 1'b0;
		p = odd;
		for (int i = 0; i < nb; i++) begin
			f[i + 1] = d[i];
			p ^= d[i];
		end
		if (pe) f[nb + 1] = p;
		return f;
	endfunction
	task automatic send(input logic [7:0] cc, input logic [3:0] cb, input logic [8:0] d, input int bc);
		int nb;
		nb = cc[6:4] == usftx_pkg::CS_NINE ? 9 : (cc[6] ? 8 : 5 + cc[5:4]);
		cfg(cc, {cb[3:2], d[8], 1'b1});
		fork
			u_remote.rx_async(bc, 2 + nb + cc[3] + cc[1], got);
			wr(usftx_pkg::OFF_DATA, {23'h0, d}, resp);
		join
		check("frame", 32'(got), 32'(frame(d, nb, cc[3], cc[2])));
		repeat (bc) @(posedge clk);
	endtask
	initial begin
		{rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		s_axi_awaddr = '0;
		s_axi_araddr = '0;
		s_axi_wdata = '0;
		s_axi_wstrb = 4'hF;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		rd(usftx_pkg::OFF_CTRL_C, rv, resp);
		check("ctrl_c", rv, 32'h30);
		rd(usftx_pkg::OFF_STATUS, rv, resp);
		check("status", rv & 32'hF, 32'h1);
		rd(5'h14, rv, resp);
		check("rresp", 32'(resp), 32'(usftx_pkg::RESP_SLVERR));
		wr(5'h18, 32'h0, resp);
		check("bresp", 32'(resp), 32'(usftx_pkg::RESP_SLVERR));
		wr(usftx_pkg::OFF_BAUD, 32'h0, resp);
		k = 0;
		for (int c = 0; c < 8; c++) for (int p = 0; p < 4; p++) for (int s = 0; s < 2; s++) begin
			send({1'b0, 3'(c), 2'(p), 1'(s), 1'b0}, 4'h0, 9'h0B6 + 9'(k * 83), 16);
			k++;
		end
		send(8'h30, 4'h4, 9'h05A, 8);
		wr(usftx_pkg::OFF_BAUD, 32'h1, resp);
		send(8'h30, 4'h0, 9'h0A5, 32);
		wr(usftx_pkg::OFF_BAUD, 32'h0, resp);
		cfg(8'h30, 4'h1);
		wr(usftx_pkg::OFF_STATUS, 32'h2, resp);
		fork
			begin
				u_remote.rx_async(16, 10, got);
				check("frame_a", 32'(got), 32'(frame(9'h03C, 8, 1'b0, 1'b0)));
				u_remote.rx_async(16, 10, got);
				check("frame_b", 32'(got), 32'(frame(9'h0C3, 8, 1'b0, 1'b0)));
			end
			begin
				wr(usftx_pkg::OFF_DATA, 32'h3C, resp);
				wr(usftx_pkg::OFF_DATA, 32'hC3, resp);
				rd(usftx_pkg::OFF_STATUS, rv, resp);
				check("dre_full", rv & 32'hB, 32'h8);
			end
		join
		repeat (32) @(posedge clk);
		rd(usftx_pkg::OFF_STATUS, rv, resp);
		check("status_done", rv & 32'hF, 32'h3);
		for (int p = 0; p < 2; p++) begin
			cfg(8'hB0 | 8'(p), 4'h1);
			fork
				u_remote.rx_sync(1'(p), 10, p ? 13'h1C00 : 13'h1E00, got);
				wr(usftx_pkg::OFF_DATA, 32'h96, resp);
			join
			check("sync_frame", 32'(got), 32'(frame(9'h096, 8, 1'b0, 1'b0)));
			rd(usftx_pkg::OFF_STATUS, rv, resp);
			check("frame_error", rv & 32'h4, 32'(p) << 2);
		end
		cfg(8'hB0, 4'h9);
		wr(usftx_pkg::OFF_DATA, 32'h5A, resp);
		k = 0;
		repeat (40) begin
			@(negedge clk);
			k += 32'(transfer_clock_pin_out);
		end
		check("xck_runs", 32'(k > 0 && k < 40), 32'h1);
		check("xck_oe_n", 32'(transfer_clock_pin_oe_n), 32'h0);
		end_of_test();
	end
endmodule // usart_frame_transmitter_test

// *** dv/usftx_properties.sv ***
// Checker on the transmitter's bus handshakes and pin behaviour
`timescale 1ns/100ps
module usftx_properties (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Register bus
	input wire logic [4:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Pins
	input wire logic serial_out_pin,
	input wire logic serial_out_oe_n,
	input wire logic transfer_clock_pin_in,
	input wire logic transfer_clock_pin_oe_n
);
	logic [7:0] cb;
	logic [7:0] cc;
	logic [1:0] quiet;
	logic [2:0] age;
	logic xq;
	logic go;
	logic slave;
	assign go = s_axi_awvalid & s_axi_awready & s_axi_wvalid & s_axi_wready;
	assign slave = quiet == 2'h3 && cc[7] && !cb[3];
	// Mirror of the control bytes as written over the bus
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cb <= 8'h00;
			cc <= 8'h30;
		end else if (go && s_axi_awaddr == usftx_pkg::OFF_CTRL_B) begin
			cb <= s_axi_wdata[7:0];
		end else if (go && s_axi_awaddr == usftx_pkg::OFF_CTRL_C) begin
			cc <= s_axi_wdata[7:0];
		end
	end
	// Cycles since the last write and since the last change edge of the clock pin
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			quiet <= 2'h0;
			age <= 3'h7;
			xq <= 1'b0;
		end else begin
			quiet <= go ? 2'h0 : (quiet == 2'h3 ? quiet : quiet + 2'h1);
			xq <= transfer_clock_pin_in;
			if (transfer_clock_pin_in != xq && transfer_clock_pin_in != cc[0])
				age <= 3'h0;
			else if (age != 3'h7)
				age <= age + 3'h1;
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	a_write_answer: assert property (go |=> s_axi_bvalid) else $error("write not answered");
	a_bresp_held: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read not answered");
	a_rdata_held: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
	a_unmapped_error: assert property (go && s_axi_awaddr > usftx_pkg::OFF_STATUS
		|=> s_axi_bresp == usftx_pkg::RESP_SLVERR) else $error("unmapped write not refused");
	a_tx_pin_owned: assert property (quiet == 2'h3 && cb[0] |-> !serial_out_oe_n)
		else $error("serial output not driven");
	a_slave_clk_in: assert property (slave |-> transfer_clock_pin_oe_n)
		else $error("slave drives clock pin");
	a_master_clk_out: assert property (quiet == 2'h3 && cc[7] && cb[3] && cb[0] |-> !transfer_clock_pin_oe_n)
		else $error("master not driving clock pin");
	a_change_edge: assert property (slave && $changed(serial_out_pin) |-> age < 3'h6)
		else $error("data changed away from change edge");
endmodule // usftx_properties
bind usftx_top usftx_properties u_props (.*);

// *** dv/usftx_remote.sv ***
// Remote serial transceiver model that decodes frames from the transmit line
`timescale 1ns/100ps
module usftx_remote (
	// Bit timing
	input wire logic clk,
	// Line from the device
	input wire logic tx_line,
	// Lines toward the device
	output logic rx_line,
	output logic xck
);
	initial begin
		rx_line = 1'b1;
		xck = 1'b0;
	end
	// Mid-bit sampling of an asynchronous frame, start bit in bit 0
	task automatic rx_async(input int bc, input int nb, output logic [12:0] w);
		w = '1;
		@(negedge tx_line);
		repeat (bc / 2) @(posedge clk);
		for (int i = 0; i < nb; i++) begin
			w[i] = tx_line;
			if (i < nb - 1)
				repeat (bc) @(posedge clk);
		end
	endtask
	// Clocked frame; the clock runs only while a frame is awaited, 64 ns period
	task automatic rx_sync(input logic pol, input int nb, input logic [12:0] tw,
		output logic [12:0] w);
		int i;
		int j;
		w = '1;
		i = 0;
		j = 0;
		xck = pol;
		#5;
		repeat (60) begin
			#32 xck = ~xck;
			if (xck != pol) begin
				rx_line = (j < 13) ? tw[j] : 1'b1;
				j++;
			end
			if (xck == pol && i < nb && (i > 0 || !tx_line)) begin
				w[i] = tx_line;
				i++;
			end
		end
	endtask
endmodule // usftx_remote

// *** rtl/usftx_pkg.sv ***
// Package with register map, field layout and timing constants for the frame transmitter
package usftx_pkg;
	localparam int unsigned ADDR_W = 5;
	localparam logic [4:0] OFF_DATA = 5'h00;
	localparam logic [4:0] OFF_CTRL_B = 5'h04;
	localparam logic [4:0] OFF_CTRL_C = 5'h08;
	localparam logic [4:0] OFF_BAUD = 5'h0C;
	localparam logic [4:0] OFF_STATUS = 5'h10;
	// Control B fields
	localparam int unsigned CB_TRANSMIT_ENABLE_BIT = 0;
	localparam int unsigned CB_NINTH = 1;
	localparam int unsigned CB_DBL = 2;
	localparam int unsigned CB_CLKDIR = 3;
	// Control C fields
	localparam int unsigned CC_POL = 0;
	localparam int unsigned CC_SBS = 1;
	localparam int unsigned CC_PM_LO = 2;
	localparam int unsigned CC_CS_LO = 4;
	localparam int unsigned CC_SYNC = 7;
	// Status fields
	localparam int unsigned ST_DRE = 0;
	localparam int unsigned ST_TXC = 1;
	localparam int unsigned ST_FE = 2;
	localparam int unsigned ST_BUSY = 3;
	localparam logic [7:0] CTRL_B_RST = 8'h00;
	localparam logic [7:0] CTRL_C_RST = 8'h30;
	localparam logic [11:0] BAUD_RST = 12'h000;
	localparam logic [2:0] CS_NINE = 3'h7;
	localparam logic [1:0] PM_EVEN = 2'h2;
	localparam logic [1:0] PM_ODD = 2'h3;
	localparam logic [3:0] DIV_NORMAL = 4'hF;
	localparam logic [3:0] DIV_DOUBLE = 4'h7;
	localparam logic [3:0] DIV_SYNC = 4'h1;
	localparam logic [3:0] DATA_BASE = 4'h5;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef enum logic [2:0] {
		USF_IDLE = 3'b000,
		USF_START = 3'b001,
		USF_DATA = 3'b011,
		USF_PAR = 3'b010,
		USF_STOP = 3'b110,
		USF_STOP2 = 3'b111
	} usftx_state_t;
endpackage : usftx_pkg

// *** rtl/usftx_top.sv ***
// Frame transmitter with shared frame format, synchronous clocking and AXI4-Lite registers
//
// Functional notes
// R1 - Sync mode: clock pin is input as slave, driven output as master.
// R2 - Input sampled on clock edge opposite to output change edge.
// R3 - Polarity clear: output changes on rising edge, sample on falling.
// R4 - Polarity set: output changes on falling edge, sample on rising.
// R5 - Support 5-9 data bits, none/even/odd parity, one or two stops.
// R6 - Start bit first, then data least significant bit first.
// R7 - Parity bit after last data bit, before first stop bit.
// R8 - Next frame may follow without gap, else line idles high.
// R9 - Start bit always low, stop bits always high.
// R10 - Idle serial lines rest high.
// R11 - One frame format setting shared by transmitter and receiver.
// R12 - Receiver ignores second stop; frame error only if first stop low.
// R13 - Parity is xor of data bits, inverted for odd.
// R14 - Transmit enable takes over serial output pin.
// R15 - Sync mode with transmitter enabled uses the clock pin.
// R16 - Writing data register fills buffer until shift register accepts it.
// R17 - Shift register loads when idle or right after last stop bit.
// R18 - Bit rate from baud divisor and double speed, or clock pin.
// R19 - Upper data bits ignored for sizes below eight.
// R20 - Nine-bit mode sends ninth bit control as ninth data bit.
// R21 - Data register empty flag set while buffer can accept.
// R22 - Sync mode: clock pin direction selects master or slave.
// R23 - External clock synchronised and edge detected, below a quarter clock.
// R24 - Size codes 0-3 give five to eight bits, code 7 nine.
// R25 - Parity code 00 off, 10 even, 11 odd, 01 reserved.
//
// Added by the designer: the AXI4-Lite register port and the address map.
`timescale 1ns/100ps
module usftx_top (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// AXI4-Lite write address
	input wire logic [4:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	// AXI4-Lite write data
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read address
	input wire logic [4:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	// AXI4-Lite read data
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Serial pins
	output logic serial_out_pin,
	output logic serial_out_oe_n,
	input wire logic serial_in_pin,
	input wire logic transfer_clock_pin_in,
	output logic transfer_clock_pin_out,
	output logic transfer_clock_pin_oe_n
);

	logic [7:0] control_b_register;
	logic [7:0] control_c_register;
	logic [11:0] baud_divisor;
	logic [8:0] tx_buffer;
	logic buf_full;
	logic tx_complete_flag;
	logic frame_error_flag;
	logic [8:0] shift_data;
	logic [3:0] bit_idx;
	logic [3:0] frame_bits;
	logic par_en;
	logic two_stop;
	logic parity_bit;
	usftx_pkg::usftx_state_t state;
	logic tick;
	logic active;

	wire transmit_enable_bit = control_b_register[usftx_pkg::CB_TRANSMIT_ENABLE_BIT];
	wire ninth_tx_bit = control_b_register[usftx_pkg::CB_NINTH];
	wire double_speed_bit = control_b_register[usftx_pkg::CB_DBL];
	wire clock_pin_direction = control_b_register[usftx_pkg::CB_CLKDIR];
	wire clock_polarity_bit = control_c_register[usftx_pkg::CC_POL];
	wire stop_bit_select = control_c_register[usftx_pkg::CC_SBS];
	wire [1:0] parity_mode_field = control_c_register[usftx_pkg::CC_PM_LO +: 2];
	wire [2:0] char_size_field = control_c_register[usftx_pkg::CC_CS_LO +: 3];
	wire sync_mode_select = control_c_register[usftx_pkg::CC_SYNC];
	wire sync_master = sync_mode_select & clock_pin_direction; // R22
	wire sync_slave = sync_mode_select & ~clock_pin_direction; // R22
	wire data_reg_empty_flag = ~buf_full; // R21

	// Data bit count from size code; reserved codes fall back to eight
	function automatic logic [3:0] data_bits(input logic [2:0] code);
		if (code == usftx_pkg::CS_NINE) begin
			data_bits = 4'h9; // R24
		end else if (code[2]) begin
			data_bits = 4'h8;
		end else begin
			data_bits = usftx_pkg::DATA_BASE + {2'h0, code[1:0]}; // R24
		end
	endfunction

	// Mask character to its size
	function automatic logic [8:0] size_mask(input logic [2:0] code);
		size_mask = (9'h1FF >> (4'h9 - data_bits(code)));
	endfunction

	// AXI4-Lite write path: address and data taken in either order
	logic aw_held;
	logic w_held;
	logic [4:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
	assign s_axi_wready = ~w_held & ~s_axi_bvalid;
	wire aw_now = aw_held | s_axi_awvalid;
	wire w_now = w_held | s_axi_wvalid;
	wire [4:0] wr_addr = aw_held ? aw_addr : s_axi_awaddr;
	wire [31:0] wr_data = w_held ? w_data : s_axi_wdata;
	wire [3:0] wr_strb = w_held ? w_strb : s_axi_wstrb;
	wire wr_fire = aw_now & w_now & ~s_axi_bvalid;
	wire wr_lane0 = wr_fire & wr_strb[0];

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= 5'h00;
			w_data <= 32'h0000_0000;
			w_strb <= 4'h0;
		end else begin
			if (s_axi_awvalid & s_axi_awready & ~wr_fire) begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end else if (wr_fire) begin
				aw_held <= 1'b0;
			end
			if (s_axi_wvalid & s_axi_wready & ~wr_fire) begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end else if (wr_fire) begin
				w_held <= 1'b0;
			end
		end
	end

	function automatic logic mapped(input logic [4:0] a);
		mapped = (a == usftx_pkg::OFF_DATA) | (a == usftx_pkg::OFF_CTRL_B) |
			(a == usftx_pkg::OFF_CTRL_C) | (a == usftx_pkg::OFF_BAUD) |
			(a == usftx_pkg::OFF_STATUS);
	endfunction

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= usftx_pkg::RESP_OKAY;
		end else if (wr_fire) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= mapped(wr_addr) ? usftx_pkg::RESP_OKAY : usftx_pkg::RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// Control registers; one format register serves both directions
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			control_b_register <= usftx_pkg::CTRL_B_RST;
			control_c_register <= usftx_pkg::CTRL_C_RST;
			baud_divisor <= usftx_pkg::BAUD_RST;
		end else begin
			if (wr_lane0 && wr_addr == usftx_pkg::OFF_CTRL_B) begin
				control_b_register <= wr_data[7:0];
			end
			if (wr_lane0 && wr_addr == usftx_pkg::OFF_CTRL_C) begin
				control_c_register <= wr_data[7:0]; // R11
			end
			if (wr_fire && wr_addr == usftx_pkg::OFF_BAUD) begin
				if (wr_strb[0]) begin
					baud_divisor[7:0] <= wr_data[7:0];
				end
				if (wr_strb[1]) begin
					baud_divisor[11:8] <= wr_data[11:8];
				end
			end
		end
	end

	// Transmit buffer and hand-off to shift register
	wire data_write = wr_lane0 && wr_addr == usftx_pkg::OFF_DATA;
	wire last_stop_done = tick & ((state == usftx_pkg::USF_STOP & ~two_stop) |
		state == usftx_pkg::USF_STOP2);
	// Sync frames start on a change edge so the start bit spans a sample edge
	wire load = buf_full & transmit_enable_bit & (last_stop_done |
		(state == usftx_pkg::USF_IDLE & (~sync_mode_select | tick))); // R17
	wire async_load = load & ~sync_mode_select;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			buf_full <= 1'b0;
			tx_buffer <= 9'h000;
		end else if (data_write & ~buf_full) begin
			buf_full <= 1'b1; // R16
			tx_buffer <= {ninth_tx_bit, wr_data[7:0]} & size_mask(char_size_field); // R19 R20
		end else if (load) begin
			buf_full <= 1'b0;
		end
	end

	// External clock: two-stage synchroniser then edge detector
	logic xck_s1;
	logic xck_s2;
	logic xck_d;
	logic rxd_s1;
	logic rxd_s2;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			xck_s1 <= 1'b0;
			xck_s2 <= 1'b0;
			xck_d <= 1'b0;
			rxd_s1 <= 1'b1;
			rxd_s2 <= 1'b1;
		end else begin
			xck_s1 <= transfer_clock_pin_in; // R23
			xck_s2 <= xck_s1;
			xck_d <= xck_s2;
			rxd_s1 <= serial_in_pin;
			rxd_s2 <= rxd_s1;
		end
	end
	wire ext_rise = xck_s2 & ~xck_d;
	wire ext_fall = ~xck_s2 & xck_d;

	// Baud generator and bit-phase divider
	logic [11:0] baud_cnt;
	logic [3:0] phase;
	logic xck_out;
	wire baud_pulse = (baud_cnt == 12'h000);
	wire [3:0] phase_top = sync_mode_select ? usftx_pkg::DIV_SYNC :
		(double_speed_bit ? usftx_pkg::DIV_DOUBLE : usftx_pkg::DIV_NORMAL);
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			baud_cnt <= usftx_pkg::BAUD_RST;
			phase <= 4'h0;
			xck_out <= 1'b0;
		end else begin
			if (baud_pulse || async_load || (wr_lane0 && wr_addr == usftx_pkg::OFF_BAUD)) begin
				baud_cnt <= baud_divisor; // R18
			end else begin
				baud_cnt <= baud_cnt - 12'h001;
			end
			// Restart bit timing at load so the start bit lasts a full bit
			if (async_load) begin
				phase <= 4'h0;
			end else if (baud_pulse) begin
				phase <= (phase >= phase_top) ? 4'h0 : phase + 4'h1;
			end
			if (baud_pulse & sync_master) begin
				xck_out <= ~xck_out;
			end
		end
	end
	// Internal clock edges in master mode, pin edges in slave mode
	wire int_rise = sync_master & baud_pulse & ~xck_out;
	wire int_fall = sync_master & baud_pulse & xck_out;
	wire clk_rise = sync_slave ? ext_rise : int_rise; // R15
	wire clk_fall = sync_slave ? ext_fall : int_fall;
	wire change_edge = clock_polarity_bit ? clk_fall : clk_rise; // R3 R4
	wire sample_edge = clock_polarity_bit ? clk_rise : clk_fall; // R2
	assign tick = sync_mode_select ? change_edge : (baud_pulse & phase == phase_top); // R18

	// Frame sequencer
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= usftx_pkg::USF_IDLE;
			shift_data <= 9'h000;
			bit_idx <= 4'h0;
			frame_bits <= 4'h8;
			par_en <= 1'b0;
			two_stop <= 1'b0;
			parity_bit <= 1'b0;
		end else if (load) begin
			state <= usftx_pkg::USF_START; // R8
			shift_data <= tx_buffer;
			bit_idx <= 4'h0;
			frame_bits <= data_bits(char_size_field); // R5
			par_en <= parity_mode_field[1]; // R25
			two_stop <= stop_bit_select;
			parity_bit <= (^tx_buffer) ^ (parity_mode_field == usftx_pkg::PM_ODD); // R13
		end else if (tick) begin
			unique case (state)
				usftx_pkg::USF_IDLE: state <= usftx_pkg::USF_IDLE;
				usftx_pkg::USF_START: state <= usftx_pkg::USF_DATA;
				usftx_pkg::USF_DATA: begin
					shift_data <= {1'b0, shift_data[8:1]}; // R6
					bit_idx <= bit_idx + 4'h1;
					if (bit_idx == frame_bits - 4'h1) begin
						state <= par_en ? usftx_pkg::USF_PAR : usftx_pkg::USF_STOP; // R7
					end
				end
				usftx_pkg::USF_PAR: state <= usftx_pkg::USF_STOP;
				usftx_pkg::USF_STOP: state <= two_stop ? usftx_pkg::USF_STOP2 : usftx_pkg::USF_IDLE;
				usftx_pkg::USF_STOP2: state <= usftx_pkg::USF_IDLE;
				default: state <= usftx_pkg::USF_IDLE;
			endcase
		end
	end
	assign active = (state != usftx_pkg::USF_IDLE);

	// Serial output bit
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			serial_out_pin <= 1'b1; // R10
		end else begin
			unique case (state)
				usftx_pkg::USF_START: serial_out_pin <= 1'b0; // R9
				usftx_pkg::USF_DATA: serial_out_pin <= shift_data[0];
				usftx_pkg::USF_PAR: serial_out_pin <= parity_bit;
				default: serial_out_pin <= 1'b1; // R9 R10
			endcase
		end
	end

	// Pin takeover: output held while enabled or while data remains
	assign serial_out_oe_n = ~(transmit_enable_bit | active | buf_full); // R14
	assign transfer_clock_pin_out = sync_master ? xck_out : 1'b0;
	assign transfer_clock_pin_oe_n = ~(sync_master & transmit_enable_bit); // R1 R15

	// Transmit complete and receiver-side first-stop check of the input line
	logic [3:0] rx_cnt;
	logic rx_busy;
	wire [3:0] rx_stop_pos = data_bits(char_size_field) + {3'h0, parity_mode_field[1]};
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			tx_complete_flag <= 1'b0;
			frame_error_flag <= 1'b0;
			rx_cnt <= 4'h0;
			rx_busy <= 1'b0;
		end else begin
			if (last_stop_done & ~buf_full) begin
				tx_complete_flag <= 1'b1;
			end else if (wr_lane0 && wr_addr == usftx_pkg::OFF_STATUS &&
				wr_data[usftx_pkg::ST_TXC]) begin
				tx_complete_flag <= 1'b0;
			end
			if (sync_mode_select & sample_edge) begin
				if (!rx_busy) begin
					rx_busy <= ~rxd_s2;
					rx_cnt <= 4'h0;
				end else if (rx_cnt == rx_stop_pos) begin
					rx_busy <= 1'b0; // R12
					frame_error_flag <= ~rxd_s2; // R12
				end else begin
					rx_cnt <= rx_cnt + 4'h1;
				end
			end
		end
	end

	// AXI4-Lite read path
	logic [31:0] rd_word;
	always_comb begin
		rd_word = 32'h0000_0000;
		unique case (s_axi_araddr)
			usftx_pkg::OFF_CTRL_B: rd_word = {24'h000000, control_b_register};
			usftx_pkg::OFF_CTRL_C: rd_word = {24'h000000, control_c_register};
			usftx_pkg::OFF_BAUD: rd_word = {20'h00000, baud_divisor};
			usftx_pkg::OFF_STATUS: rd_word = {28'h0000000, active, frame_error_flag,
				tx_complete_flag, data_reg_empty_flag}; // R21
			default: rd_word = 32'h0000_0000;
		endcase
	end
	assign s_axi_arready = ~s_axi_rvalid;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= usftx_pkg::RESP_OKAY;
		end else if (s_axi_arvalid & s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rd_word;
			s_axi_rresp <= mapped(s_axi_araddr) ? usftx_pkg::RESP_OKAY : usftx_pkg::RESP_SLVERR;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

endmodule // usftx_top
